/* rtl/irq_pkg.sv */
package irq_pkg;
	// Source counts and widths
	localparam int NUM_USER = 4;
	localparam int NUM_TRAP = 4;
	localparam int NUM_SRC = NUM_USER + NUM_TRAP;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;
	localparam int PRIO_W = 3;
	localparam int LVL_W = 4;
	localparam int VEC_W = 7;
	localparam int HOLD_W = 16;
	localparam int STACK_DEPTH = 8;

	// Register offsets (word index on the plain port)
	localparam logic [ADDR_W-1:0] ADDR_PRIO = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_FLAG = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_LEVEL = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_HOLD = 4'h6;

	// Priority register layout: field i at bits i*4+2..i*4, bit i*4+3 reads zero
	// Field 0 ch6 done, 1 ch7 done, 2 CAN A transmit, 3 CAN B transmit
	localparam int PRIO_STRIDE = 4;
	localparam logic [PRIO_W-1:0] PRIO_RST = 3'h4;
	localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
	localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;

	// Status register layout
	localparam int STAT_LVL_LSB = 8;
	localparam int STAT_VEC_LSB = 0;

	// Control register layout
	localparam int CTRL_NEST_BIT = 15;

	// Level register low byte layout
	localparam int LVL_IPL_LSB = 5;
	localparam int LVL_IPL3_BIT = 3;

	// Level thresholds
	localparam logic [LVL_W-1:0] TRAP_LVL_BASE = 4'h8;
	localparam logic [LVL_W-1:0] USER_LVL_MAX = 4'h7;
	localparam logic [LVL_W-1:0] LVL_ZERO = 4'h0;
endpackage : irq_pkg

/* rtl/arb_if.sv */
`timescale 1ns/1ps
interface arb_if #(parameter int N = 8, parameter int LW = 4);
	logic [N-1:0] valid;
	logic [N-1:0][LW-1:0] level;
	logic best_valid;
	logic [$clog2(N)-1:0] best_idx;
	logic [LW-1:0] best_level;
	modport requester (output valid, output level, input best_valid, input best_idx, input best_level);
	modport arbiter (input valid, input level, output best_valid, output best_idx, output best_level);
endinterface : arb_if

/* rtl/irq_arbiter.sv */
`timescale 1ns/1ps
module irq_arbiter #(
	parameter int N = 8,
	parameter int LW = 4
) (
	// Candidates and winner
	arb_if.arbiter arb
);
	always_comb begin
		arb.best_valid = 1'b0;
		arb.best_idx = '0;
		arb.best_level = '0;
		// Ascending scan with strict compare keeps the lowest index on a tie
		for (int i = 0; i < N; i++) begin
			if (arb.valid[i] && (!arb.best_valid || arb.level[i] > arb.best_level)) begin
				arb.best_valid = 1'b1;
				arb.best_idx = ($clog2(N))'(i);
				arb.best_level = arb.level[i];
			end
		end
	end
endmodule : irq_arbiter

/* rtl/interrupt_priority_controller.sv */
`timescale 1ns/1ps
// Functional notes
// - Three-bit priority per user source: 7 highest, 1 lowest, 0 never taken.
// - Priority fields at bits 14-12, 10-8, 6-4, 2-0; bits 15,11,7,3 read zero.
// - Every user priority field resets to 4.
// - Status bits 11-8 show the new CPU level 0-11, reset zero.
// - Status bits 6-0 show the pending vector: traps 0-3, user sources 4-7.
// - Nesting disable bit 15 stops user sources preempting an interrupt in service.
// - User request only with flag set, enable set and non-zero priority.
// - Acceptance leaves the flag set; a still-set flag requests again after return.
// - Return restores the level in force before the interrupt was taken.
// - Trap flags stay set until software clears them; otherwise trap re-enters.
// - CPU level 7 in the level register low byte blocks all user interrupts.
// - CPU levels 0-7 mask only user sources; a trap at 8-11 is taken unless the CPU level is at or above it.
// - Timed hold blocks priorities 1-6 for a period; priority 7 passes.
module interrupt_priority_controller
	import irq_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Peripheral and trap events
	input wire logic [NUM_USER-1:0] user_evt,
	input wire logic [NUM_TRAP-1:0] trap_evt,
	// Processor core
	input wire logic core_ack,
	input wire logic core_ret,
	input wire logic core_hold,
	output logic core_req,
	output logic [LVL_W-1:0] core_req_level,
	output logic [VEC_W-1:0] core_req_vector,
	output logic [LVL_W-1:0] core_cpu_level,
	output logic core_hold_active,
	// Summary interrupt
	output logic irq
);
	localparam int SP_W = $clog2(DEPTH + 1);
	localparam int IDX_W = $clog2(NUM_SRC);
	localparam logic [SP_W-1:0] SP_FULL = SP_W'(DEPTH);

	typedef struct packed {
		logic [NUM_USER-1:0][PRIO_W-1:0] prio;
		logic [NUM_USER-1:0] flag;
		logic [NUM_USER-1:0] en;
		logic [NUM_TRAP-1:0] trapf;
		logic nest_dis;
		logic [LVL_W-1:0] cpu_level;
		logic [DEPTH-1:0][LVL_W-1:0] stack;
		logic [SP_W-1:0] sp;
		logic [HOLD_W-1:0] hold_len;
		logic [HOLD_W-1:0] hold_cnt;
		logic hold_act;
		logic req;
		logic [LVL_W-1:0] req_level;
		logic [VEC_W-1:0] req_vec;
		logic [LVL_W-1:0] stat_level;
		logic [VEC_W-1:0] stat_vec;
		logic [DATA_W-1:0] rdata;
		logic irq;
	} state_s;

	state_s st_q;
	state_s st_d;

	arb_if #(.N(NUM_SRC), .LW(LVL_W)) arb ();

	irq_arbiter #(.N(NUM_SRC), .LW(LVL_W)) u_arb (
		.arb(arb)
	);

	function automatic logic wr_hit(input logic [ADDR_W-1:0] a);
		wr_hit = reg_wr && (reg_addr == a);
	endfunction : wr_hit

	function automatic logic [DATA_W-1:0] prio_word(input logic [NUM_USER-1:0][PRIO_W-1:0] p);
		prio_word = '0;
		for (int i = 0; i < NUM_USER; i++) begin
			prio_word[i*PRIO_STRIDE +: PRIO_W] = p[i];
		end
	endfunction : prio_word

	logic hold_on;
	logic nest_block;
	assign hold_on = (st_q.hold_cnt != '0);
	assign nest_block = st_q.nest_dis && (st_q.sp != '0);

	// Candidate list: traps on the low indices, user sources above them
	always_comb begin
		for (int t = 0; t < NUM_TRAP; t++) begin
			arb.level[t] = TRAP_LVL_BASE + LVL_W'(t);
			// Traps ignore any user-range CPU level
			arb.valid[t] = st_q.trapf[t] && (st_q.cpu_level <= USER_LVL_MAX || arb.level[t] > st_q.cpu_level);
		end
		for (int u = 0; u < NUM_USER; u++) begin
			arb.level[NUM_TRAP+u] = {1'b0, st_q.prio[u]};
			arb.valid[NUM_TRAP+u] = st_q.flag[u] && st_q.en[u] && (st_q.prio[u] != PRIO_OFF)
				&& ({1'b0, st_q.prio[u]} > st_q.cpu_level)
				&& !(hold_on && st_q.prio[u] != PRIO_TOP)
				&& !nest_block;
		end
	end

	always_comb begin
		logic [NUM_USER-1:0] fclr;
		logic [NUM_TRAP-1:0] tclr;
		fclr = '0;
		tclr = '0;
		st_d = st_q;
		// Flags: set wins over a same-cycle write-one clear
		if (wr_hit(ADDR_FLAG)) begin
			fclr = reg_wdata[NUM_USER-1:0];
		end
		if (wr_hit(ADDR_CTRL)) begin
			tclr = reg_wdata[NUM_TRAP-1:0];
			st_d.nest_dis = reg_wdata[CTRL_NEST_BIT];
		end
		st_d.flag = (st_q.flag & ~fclr) | user_evt;
		st_d.trapf = (st_q.trapf & ~tclr) | trap_evt;
		if (wr_hit(ADDR_PRIO)) begin
			for (int i = 0; i < NUM_USER; i++) begin
				st_d.prio[i] = reg_wdata[i*PRIO_STRIDE +: PRIO_W];
			end
		end
		if (wr_hit(ADDR_ENABLE)) begin
			st_d.en = reg_wdata[NUM_USER-1:0];
		end
		if (wr_hit(ADDR_LEVEL)) begin
			// Software sets only the low three level bits; the top level bit is set only by acceptance and return
			st_d.cpu_level = {st_q.cpu_level[LVL_W-1], reg_wdata[LVL_IPL_LSB +: PRIO_W]};
		end
		if (wr_hit(ADDR_HOLD)) begin
			st_d.hold_len = reg_wdata;
		end
		// Timed hold countdown
		if (core_hold) begin
			st_d.hold_cnt = st_q.hold_len;
		end else if (hold_on) begin
			st_d.hold_cnt = st_q.hold_cnt - HOLD_W'(1);
		end
		// Registered copy so the hold status pin comes straight from a flop
		st_d.hold_act = (st_d.hold_cnt != '0);
		// Acceptance pushes the old level; the source flag is left alone
		if (core_ack && st_q.req) begin
			if (st_q.sp != SP_FULL) begin
				st_d.stack[st_q.sp] = st_q.cpu_level;
				st_d.sp = st_q.sp + SP_W'(1);
			end
			st_d.cpu_level = st_q.req_level;
		end else if (core_ret && st_q.sp != '0) begin
			st_d.sp = st_q.sp - SP_W'(1);
			st_d.cpu_level = st_q.stack[st_q.sp - SP_W'(1)];
		end
		// Request toward the core; withdrawn for the cycle after an acceptance
		st_d.req = arb.best_valid && !(core_ack && st_q.req);
		st_d.req_level = arb.best_valid ? arb.best_level : LVL_ZERO;
		st_d.req_vec = arb.best_valid ? VEC_W'(arb.best_idx) : '0;
		st_d.stat_level = st_d.req_level;
		st_d.stat_vec = st_d.req_vec;
		st_d.irq = |(st_q.flag & st_q.en);
		// Read data stand for exactly one cycle
		st_d.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_PRIO: begin
					st_d.rdata = prio_word(st_q.prio);
				end
				ADDR_STATUS: begin
					st_d.rdata[STAT_LVL_LSB +: LVL_W] = st_q.stat_level;
					st_d.rdata[STAT_VEC_LSB +: VEC_W] = st_q.stat_vec;
				end
				ADDR_CTRL: begin
					st_d.rdata[CTRL_NEST_BIT] = st_q.nest_dis;
					st_d.rdata[NUM_TRAP-1:0] = st_q.trapf;
				end
				ADDR_FLAG: begin
					st_d.rdata[NUM_USER-1:0] = st_q.flag;
				end
				ADDR_ENABLE: begin
					st_d.rdata[NUM_USER-1:0] = st_q.en;
				end
				ADDR_LEVEL: begin
					st_d.rdata[LVL_IPL_LSB +: PRIO_W] = st_q.cpu_level[PRIO_W-1:0];
					st_d.rdata[LVL_IPL3_BIT] = st_q.cpu_level[LVL_W-1];
				end
				ADDR_HOLD: begin
					st_d.rdata = st_q.hold_len;
				end
				default: begin
					st_d.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
			for (int i = 0; i < NUM_USER; i++) begin
				st_q.prio[i] <= PRIO_RST;
			end
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign core_req = st_q.req;
	assign core_req_level = st_q.req_level;
	assign core_req_vector = st_q.req_vec;
	assign core_cpu_level = st_q.cpu_level;
	assign core_hold_active = st_q.hold_act;
	assign irq = st_q.irq;

	localparam logic [VEC_W-1:0] USER_VEC0 = VEC_W'(NUM_TRAP);

	property p_prio_reset;
		@(posedge ref_clk) disable iff (!resetn)
		!$past(resetn) |-> (prio_word(st_q.prio) == {NUM_USER{1'b0, PRIO_RST}});
	endproperty
	a_prio_reset: assert property (p_prio_reset) else $error("priority fields not 4 after reset");

	property p_prio_reserved;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_rd && reg_addr == ADDR_PRIO) |=> (reg_rdata[15] == 1'b0 && reg_rdata[11] == 1'b0
			&& reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0 && reg_rdata[6:4] == $past(st_q.prio[1]));
	endproperty
	a_prio_reserved: assert property (p_prio_reserved) else $error("priority read layout wrong");

	property p_user_gate;
		@(posedge ref_clk) disable iff (!resetn)
		(core_req && core_req_vector >= USER_VEC0) |->
			// Whole vectors come from the past so the index is the vector granted now
			(|($past(st_q.flag & st_q.en) & (NUM_USER'(1) << (core_req_vector - USER_VEC0)))
			&& core_req_level != LVL_ZERO);
	endproperty
	a_user_gate: assert property (p_user_gate) else $error("user request without flag, enable or priority");

	property p_take_level;
		@(posedge ref_clk) disable iff (!resetn)
		(core_ack && core_req) |=> (core_cpu_level == $past(core_req_level) && !core_req);
	endproperty
	a_take_level: assert property (p_take_level) else $error("cpu level not taken from accepted source");

	property p_flag_kept;
		@(posedge ref_clk) disable iff (!resetn)
		(core_ack && !reg_wr) |=> ((st_q.flag & $past(st_q.flag)) == $past(st_q.flag));
	endproperty
	a_flag_kept: assert property (p_flag_kept) else $error("acceptance cleared a flag");

	property p_return;
		@(posedge ref_clk) disable iff (!resetn)
		(core_ret && !(core_ack && core_req) && st_q.sp != '0) |=>
			(core_cpu_level == $past(st_q.stack[st_q.sp - SP_W'(1)]) && st_q.sp == $past(st_q.sp) - SP_W'(1));
	endproperty
	a_return: assert property (p_return) else $error("return did not restore level");

	property p_level7_block;
		@(posedge ref_clk) disable iff (!resetn)
		($past(st_q.cpu_level) >= USER_LVL_MAX) |-> !(core_req && core_req_vector >= USER_VEC0);
	endproperty
	a_level7_block: assert property (p_level7_block) else $error("user request above level 7 block");

	property p_trap_taken;
		@(posedge ref_clk) disable iff (!resetn)
		($past(st_q.trapf) != '0 && $past(st_q.cpu_level) <= USER_LVL_MAX && !$past(core_ack && core_req))
			|-> (core_req && core_req_vector < USER_VEC0 && core_req_level >= TRAP_LVL_BASE);
	endproperty
	a_trap_taken: assert property (p_trap_taken) else $error("trap not requested");

	property p_trap_sticky;
		@(posedge ref_clk) disable iff (!resetn)
		!(reg_wr && reg_addr == ADDR_CTRL) |=> ((st_q.trapf & $past(st_q.trapf)) == $past(st_q.trapf));
	endproperty
	a_trap_sticky: assert property (p_trap_sticky) else $error("trap flag dropped without software clear");

	property p_hold;
		@(posedge ref_clk) disable iff (!resetn)
		($past(hold_on) && core_req && core_req_vector >= USER_VEC0) |-> (core_req_level == {1'b0, PRIO_TOP});
	endproperty
	a_hold: assert property (p_hold) else $error("timed hold let a low priority through");

	property p_nest;
		@(posedge ref_clk) disable iff (!resetn)
		$past(nest_block) |-> !(core_req && core_req_vector >= USER_VEC0);
	endproperty
	a_nest: assert property (p_nest) else $error("nesting disable allowed preemption");

	property p_status;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_rd && reg_addr == ADDR_STATUS) |=>
			(reg_rdata[STAT_VEC_LSB +: VEC_W] == $past(core_req_vector) && reg_rdata[15:12] == 4'h0
			&& reg_rdata[7] == 1'b0 && reg_rdata[STAT_LVL_LSB +: LVL_W] == $past(core_req_level));
	endproperty
	a_status: assert property (p_status) else $error("status read mismatch");

	// Winner check: no candidate beats the granted one, and none below it ties
	function automatic logic win_ok(input logic [NUM_SRC-1:0] v, input logic [NUM_SRC-1:0][LVL_W-1:0] l,
		input logic [VEC_W-1:0] w, input logic [LVL_W-1:0] wl);
		win_ok = (w < VEC_W'(NUM_SRC)) && v[w[IDX_W-1:0]] && (l[w[IDX_W-1:0]] == wl);
		for (int i = 0; i < NUM_SRC; i++) begin
			if (v[i] && (l[i] > wl || (l[i] == wl && VEC_W'(i) < w))) begin
				win_ok = 1'b0;
			end
		end
	endfunction : win_ok

	property p_winner;
		@(posedge ref_clk) disable iff (!resetn)
		core_req |-> win_ok($past(arb.valid), $past(arb.level), core_req_vector, core_req_level);
	endproperty
	a_winner: assert property (p_winner) else $error("granted source is not the best candidate");

	property p_hold_load;
		@(posedge ref_clk) disable iff (!resetn)
		core_hold |=> (st_q.hold_cnt == $past(st_q.hold_len));
	endproperty
	a_hold_load: assert property (p_hold_load) else $error("timed hold did not load its length");

	property p_level_reset;
		@(posedge ref_clk) disable iff (!resetn)
		!$past(resetn) |-> (st_q.stat_level == LVL_ZERO && core_cpu_level == LVL_ZERO);
	endproperty
	a_level_reset: assert property (p_level_reset) else $error("level not zero after reset");

	property p_push_level;
		@(posedge ref_clk) disable iff (!resetn)
		(core_ack && core_req && st_q.sp != SP_FULL) |=>
			(st_q.sp == $past(st_q.sp) + SP_W'(1) && st_q.stack[$past(st_q.sp)] == $past(core_cpu_level));
	endproperty
	a_push_level: assert property (p_push_level) else $error("acceptance did not save the old level");

	property p_sw_level;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_wr && reg_addr == ADDR_LEVEL && !core_ack && !core_ret) |=>
			(core_cpu_level[PRIO_W-1:0] == $past(reg_wdata[LVL_IPL_LSB +: PRIO_W]));
	endproperty
	a_sw_level: assert property (p_sw_level) else $error("software level write not applied");
endmodule : interrupt_priority_controller

/* dv/core_model.sv */
`timescale 1ns/1ps
module core_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// From the controller
	input wire logic core_req,
	// Bench commands
	input wire logic ack_go,
	input wire logic [3:0] ack_dly,
	input wire logic ret_cmd,
	// To the controller
	output logic core_ack,
	output logic core_ret
);
	logic armed_q;
	logic [3:0] wait_q;
	// Only one ack per command, so a slow core really leaves the request standing
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			armed_q <= 1'b0;
			wait_q <= 4'h0;
			core_ack <= 1'b0;
			core_ret <= 1'b0;
		end else begin
			core_ack <= 1'b0;
			core_ret <= ret_cmd;
			if (ack_go) armed_q <= 1'b1;
			if (armed_q && core_req && !core_ack) begin
				// Taking service never touches the flags; the bench clears them
				if (wait_q == ack_dly) begin
					core_ack <= 1'b1;
					armed_q <= 1'b0;
					wait_q <= 4'h0;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule : core_model

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import irq_pkg::*;
	logic ref_clk, resetn, reg_wr, reg_rd, core_hold, core_ack, core_ret, ack_go, ret_cmd;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata;
	logic [3:0] user_evt, trap_evt, ack_dly;
	logic core_req, core_hold_active, irq;
	logic [LVL_W-1:0] core_req_level, core_cpu_level;
	logic [VEC_W-1:0] core_req_vector;
	int miscompares = 0;
	int checks_done = 0;

	interrupt_priority_controller dut_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.user_evt(user_evt), .trap_evt(trap_evt), .core_ack(core_ack), .core_ret(core_ret),
		.core_hold(core_hold), .core_req(core_req), .core_req_level(core_req_level),
		.core_req_vector(core_req_vector), .core_cpu_level(core_cpu_level),
		.core_hold_active(core_hold_active), .irq(irq));
	core_model core_u (.ref_clk(ref_clk), .resetn(resetn), .core_req(core_req), .ack_go(ack_go),
		.ack_dly(ack_dly), .ret_cmd(ret_cmd), .core_ack(core_ack), .core_ret(core_ret));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task conclude;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : conclude

	task chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	// Every driver starts on a rising edge, so requests change right after it
	task wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd

	task ev(input logic [3:0] u, input logic [3:0] t);
		@(posedge ref_clk);
		user_evt <= u;
		trap_evt <= t;
		@(posedge ref_clk);
		user_evt <= 4'h0;
		trap_evt <= 4'h0;
	endtask : ev

	task pulse_ctl(input int which);
		@(posedge ref_clk);
		if (which == 0) ack_go <= 1'b1;
		else if (which == 1) ret_cmd <= 1'b1;
		else core_hold <= 1'b1;
		@(posedge ref_clk);
		ack_go <= 1'b0;
		ret_cmd <= 1'b0;
		core_hold <= 1'b0;
	endtask : pulse_ctl

	// Level and vector are only meaningful while a request stands
	task cc(input logic r, input logic [3:0] l, input logic [6:0] v);
		chk(r ? {4'h0, core_req, core_req_level, core_req_vector} : {15'h0, core_req}, {4'h0, r, l, v});
	endtask : cc

	initial begin
		{resetn, reg_wr, reg_rd, core_hold, ack_go, ret_cmd} = 6'h00;
		{reg_addr, reg_wdata, user_evt, trap_evt, ack_dly} = '0;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(ADDR_PRIO, 16'h4444);
		rd(ADDR_STATUS, 16'h0000);
		rd(4'hF, 16'h0000);
		wr(ADDR_PRIO, 16'hFFFF);
		rd(ADDR_PRIO, 16'h7777);
		wr(ADDR_PRIO, 16'h7550);
		wr(ADDR_ENABLE, 16'h0001);
		ev(4'h1, 4'h0);
		cyc(3);
		cc(1'b0, 4'h0, 7'h00);
		chk({15'h0, irq}, 16'h0001);
		wr(ADDR_ENABLE, 16'h0000);
		cyc(2);
		chk({15'h0, irq}, 16'h0000);
		wr(ADDR_FLAG, 16'h0001);
		wr(ADDR_ENABLE, 16'h000F);
		cyc(2);
		chk({15'h0, irq}, 16'h0000);
		rd(ADDR_ENABLE, 16'h000F);
		ev(4'h6, 4'h0);
		cyc(3);
		cc(1'b1, 4'h5, 7'h05);
		rd(ADDR_STATUS, 16'h0505);
		ack_dly <= 4'h2;
		pulse_ctl(0);
		cyc(6);
		chk({12'h0, core_cpu_level}, 16'h0005);
		cc(1'b0, 4'h0, 7'h00);
		rd(ADDR_FLAG, 16'h0006);
		wr(ADDR_CTRL, 16'h8000);
		ev(4'h8, 4'h0);
		cyc(3);
		cc(1'b0, 4'h0, 7'h00);
		wr(ADDR_CTRL, 16'h0000);
		cyc(3);
		cc(1'b1, 4'h7, 7'h07);
		ack_dly <= 4'h0;
		pulse_ctl(0);
		cyc(4);
		chk({12'h0, core_cpu_level}, 16'h0007);
		pulse_ctl(1);
		cyc(3);
		chk({12'h0, core_cpu_level}, 16'h0005);
		cc(1'b1, 4'h7, 7'h07);
		wr(ADDR_FLAG, 16'h0008);
		cyc(3);
		cc(1'b0, 4'h0, 7'h00);
		pulse_ctl(1);
		cyc(3);
		chk({12'h0, core_cpu_level}, 16'h0000);
		cc(1'b1, 4'h5, 7'h05);
		wr(ADDR_LEVEL, 16'h00E0);
		cyc(3);
		cc(1'b0, 4'h0, 7'h00);
		ev(4'h0, 4'h1);
		cyc(3);
		cc(1'b1, 4'h8, 7'h00);
		pulse_ctl(0);
		cyc(3);
		chk({12'h0, core_cpu_level}, 16'h0008);
		rd(ADDR_LEVEL, 16'h0008);
		rd(ADDR_CTRL, 16'h0001);
		wr(ADDR_CTRL, 16'h0001);
		cyc(3);
		cc(1'b0, 4'h0, 7'h00);
		pulse_ctl(1);
		cyc(3);
		chk({12'h0, core_cpu_level}, 16'h0007);
		wr(ADDR_LEVEL, 16'h0000);
		cyc(3);
		cc(1'b1, 4'h5, 7'h05);
		wr(ADDR_HOLD, 16'h0014);
		rd(ADDR_HOLD, 16'h0014);
		pulse_ctl(2);
		cyc(3);
		chk({15'h0, core_hold_active}, 16'h0001);
		cc(1'b0, 4'h0, 7'h00);
		ev(4'h8, 4'h0);
		cyc(3);
		cc(1'b1, 4'h7, 7'h07);
		wr(ADDR_FLAG, 16'h0008);
		cyc(25);
		chk({15'h0, core_hold_active}, 16'h0000);
		cc(1'b1, 4'h5, 7'h05);
		// Mid-run reset must bring the written priorities back to their reset value
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rd(ADDR_PRIO, 16'h4444);
		rd(ADDR_STATUS, 16'h0000);
		cc(1'b0, 4'h0, 7'h00);
		conclude();
	end

	// Whole sequence is under two hundred cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		conclude();
	end
endmodule : testbench
